// *** verilog/imr_pkg.sv ***
package imr_pkg;
    // ==========================================================
    // Message address layout (A[19:0] of the interrupt address)
    localparam int A_HINT    = 3;
    localparam int A_DM_IO   = 2;
    localparam int A_DM_CPU  = 5;
    localparam int A_DST_LO  = 12;
    localparam int IDCHK_BIT = 15;
    localparam int STS_LOGZ  = 1;
    localparam int ENT_EN    = 0;
    localparam int ENT_LOG   = 8;
    localparam int ENT_PHY   = 16;
    localparam int ENT_CLU   = 31;
    localparam int NCLU_TRK  = 15;
    // ==========================================================
    // APB register map
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_TABLE  = 12'h100;
    localparam logic [11:0] OFS_TEND   = 12'h17C;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [7:0]  ALL_ONES8  = 8'hFF;
    localparam logic [63:0] LRU_RST    = 64'h0000_0000_0000_0000;
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        from_cpu;
        logic [1:0]  src_bus;
        logic [19:0] addr;
        logic [7:0]  vector;
    } imr_msg_type;
    typedef struct packed {
        logic       en;
        logic [7:0] logical_id_field;
        logic [7:0] physical_id_field;
    } imr_entry_type;
    typedef struct packed {
        logic [4:0] idx;
        logic       en;
        logic [7:0] logical_id_field;
        logic [7:0] physical_id_field;
        logic       cluster;
    } imr_upd_type;
    typedef enum logic [1:0] {
        MODE_PHYS,
        MODE_FLAT,
        MODE_CLUSTER
    } imr_mode_type;
endpackage

// *** verilog/imr_router.sv ***
`timescale 1ns/1ps
// What this block does
// R01 - Directed message from I/O goes out on every processor bus
// R02 - Directed message from a processor goes to the other buses
// R03 - Redirectable messages pass redirection first, then go to all buses
// R04 - Table of 32 per-thread entries: enable, logical ID, physical ID
// R05 - Entry zero carries global cluster bit, reset to flat (0)
// R06 - Priority-update cycle copies enable and IDs into its entry
// R07 - Software may also write the table entries
// R08 - Cluster bit copied only if enabled, logical ID nonzero, ID check set
// R09 - Enabled update with zero logical ID sets status bit 1
// R10 - Table register is the serialization point for later redirections
// R11 - Hint address bit A[3]=1 marks a redirection request
// R12 - Mode bit A2 for I/O, Ab5 for processor; cluster bit picks logical kind
// R13 - Hint clear: broadcast, source bus excluded for processor messages
// R14 - Physical hint with enabled target: clear hint, send to all buses
// R15 - Flat hint: LRU pick of enabled named agents, one-hot destination
// R16 - Candidate needs its destination bit and its entry enable set
// R17 - Cluster hint: LRU pick within cluster, keep cluster, rewrite local ID
// R18 - Fifteen 4-way trackers for clusters and one 8-way for flat
// R19 - End-of-interrupt goes to every port not marked suppressed
// R20 - End-of-interrupt leaves as a message TLP on the ports
// R21 - Hint 0 directed, 1 redirectable; mode 0 physical, 1 logical
// R22 - Cluster destination: upper nibble cluster, lower nibble agent bits
// R23 - Winner becomes most recently used in the consulted tracker
module imr_router #(
    parameter int NBUS  = 4,
    parameter int NPORT = 8
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  msg_valid,
    input  wire imr_pkg::imr_msg_type  msg_in,
    input  wire logic                  upd_valid,
    input  wire imr_pkg::imr_upd_type  upd_in,
    input  wire logic                  eoi_valid,
    input  wire logic [7:0]            eoi_vector,
    output logic                       fsb_valid_reg,
    output logic      [NBUS-1:0]       fsb_mask_reg,
    output imr_pkg::imr_msg_type       fsb_msg_reg,
    output logic                       tlp_valid_reg,
    output logic      [NPORT-1:0]      tlp_port_reg,
    output logic      [7:0]            tlp_vector_reg
);
    import imr_pkg::*;

    if (NBUS < 2 || NBUS > 4) begin : g_chk_bus
        $error("NBUS must be 2 to 4");
    end
    if (NPORT < 1 || NPORT > 15) begin : g_chk_port
        $error("NPORT must be 1 to 15");
    end

    // ==========================================================
    // State
    imr_entry_type    tbl_reg [32]; // R04
    logic             cluster_reg;
    logic [31:0]      ctrl_reg;
    logic             sts_reg;
    logic [63:0]      flat_lru_reg;
    logic [63:0]      clu_lru_reg [NCLU_TRK];
    logic             wr_en;
    logic             rd_set;
    logic             tbl_hit;
    logic [4:0]       tbl_idx;
    logic             sts_set;
    logic             clu_load;
    logic [NBUS-1:0]  all_bus;

    assign all_bus  = {NBUS{1'b1}};
    assign wr_en    = psel && penable && pready && pwrite;
    assign rd_set   = psel && !penable;
    assign tbl_hit  = paddr >= OFS_TABLE && paddr <= OFS_TEND && paddr[1:0] == 2'b00;
    assign tbl_idx  = paddr[6:2];
    assign sts_set  = upd_valid && upd_in.en && upd_in.logical_id_field == 8'h00;
    assign clu_load = upd_valid && upd_in.en && upd_in.logical_id_field != 8'h00
                      && ctrl_reg[IDCHK_BIT];

    // ==========================================================
    // LRU matrix: row i bit j set means i used after j
    function automatic logic [2:0] lru_pick(input logic [7:0] c,
                                            input logic [63:0] m);
        logic [2:0] w;
        w = 3'd0;
        for (int i = 7; i >= 0; i--) begin
            if (c[i] && (m[i*8 +: 8] & c) == 8'h00) begin
                w = i[2:0];
            end
        end
        return w;
    endfunction

    function automatic logic [63:0] lru_touch(input logic [63:0] m,
                                              input logic [2:0] w);
        logic [63:0] r;
        r = m;
        r[int'(w)*8 +: 8] = ALL_ONES8;
        for (int i = 0; i < 8; i++) begin
            r[i*8 + int'(w)] = 1'b0;
        end
        return r;
    endfunction

    // ==========================================================
    // Redirection decode
    imr_mode_type     mode;
    logic             hint;
    logic [7:0]       dst;
    logic [7:0]       flat_c;
    logic [3:0]       clu_c;
    logic             phys_hit;
    logic [2:0]       win;
    logic             has_win;
    logic             use_flat;
    logic             use_clu;
    imr_msg_type      msg_out;
    logic [NBUS-1:0]  mask_next;

    always_comb begin
        hint = msg_in.addr[A_HINT]; // R11 R21
        dst  = msg_in.addr[A_DST_LO +: 8];
        if (!(msg_in.from_cpu ? msg_in.addr[A_DM_CPU] : msg_in.addr[A_DM_IO])) begin
            mode = MODE_PHYS; // R12
        end else if (cluster_reg) begin
            mode = MODE_CLUSTER;
        end else begin
            mode = MODE_FLAT;
        end
        flat_c   = 8'h00;
        clu_c    = 4'h0;
        phys_hit = 1'b0;
        for (int e = 0; e < 32; e++) begin
            for (int j = 0; j < 8; j++) begin
                if (tbl_reg[e].en && dst[j] && tbl_reg[e].logical_id_field == 8'(1 << j)) begin
                    flat_c[j] = 1'b1; // R16
                end
            end
            for (int k = 0; k < 4; k++) begin
                if (tbl_reg[e].en && dst[k]
                    && tbl_reg[e].logical_id_field == {dst[7:4], 4'(1 << k)}) begin
                    clu_c[k] = 1'b1; // R16 R22
                end
            end
            if (tbl_reg[e].en && tbl_reg[e].physical_id_field == dst) begin
                phys_hit = 1'b1;
            end
        end
        use_flat = hint && mode == MODE_FLAT && flat_c != 8'h00;
        use_clu  = hint && mode == MODE_CLUSTER && clu_c != 4'h0
                   && dst[7:4] != 4'hF;
        if (use_flat) begin
            win = lru_pick(flat_c, flat_lru_reg);
        end else if (use_clu) begin
            win = lru_pick({4'h0, clu_c}, clu_lru_reg[dst[7:4]]);
        end else begin
            win = 3'd0;
        end
        has_win = use_flat || use_clu;
        msg_out = msg_in;
        if (hint && mode == MODE_PHYS && phys_hit) begin
            msg_out.addr[A_HINT] = 1'b0; // R14
        end
        if (use_flat) begin
            msg_out.addr[A_DST_LO +: 8] = 8'(1 << win); // R15
            msg_out.addr[A_HINT]        = 1'b0;
        end
        if (use_clu) begin
            msg_out.addr[A_DST_LO +: 8] = {dst[7:4], 4'(1 << win)}; // R17
            msg_out.addr[A_HINT]        = 1'b0;
        end
        if (!hint && msg_in.from_cpu) begin
            mask_next = all_bus & ~NBUS'(1 << msg_in.src_bus); // R02 R13
        end else begin
            mask_next = all_bus; // R01 R03
        end
    end

    // ==========================================================
    // Front-side bus output
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fsb_valid_reg <= 1'b0;
            fsb_mask_reg  <= '0;
            fsb_msg_reg   <= '0;
        end else begin
            fsb_valid_reg <= msg_valid;
            fsb_mask_reg  <= msg_valid ? mask_next : '0;
            fsb_msg_reg   <= msg_out;
        end
    end

    // ==========================================================
    // LRU trackers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flat_lru_reg <= LRU_RST;
        end else if (msg_valid && use_flat) begin
            flat_lru_reg <= lru_touch(flat_lru_reg, win); // R18 R23
        end
    end

    for (genvar c = 0; c < NCLU_TRK; c++) begin : g_clu
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                clu_lru_reg[c] <= LRU_RST;
            end else if (msg_valid && use_clu && dst[7:4] == 4'(c)) begin
                clu_lru_reg[c] <= lru_touch(clu_lru_reg[c], win); // R18 R23
            end
        end
    end

    // ==========================================================
    // Agent state table; updates land here before later redirections
    for (genvar e = 0; e < 32; e++) begin : g_tbl
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                tbl_reg[e] <= '0;
            end else if (upd_valid && upd_in.idx == 5'(e)) begin
                tbl_reg[e] <= '{upd_in.en, upd_in.logical_id_field, upd_in.physical_id_field}; // R06 R10
            end else if (wr_en && tbl_hit && tbl_idx == 5'(e)) begin
                tbl_reg[e] <= '{pwdata[ENT_EN], pwdata[ENT_LOG +: 8],
                               pwdata[ENT_PHY +: 8]}; // R07
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cluster_reg <= 1'b0; // R05
        end else if (clu_load) begin
            cluster_reg <= upd_in.cluster; // R08
        end else if (wr_en && paddr == OFS_TABLE) begin
            cluster_reg <= pwdata[ENT_CLU]; // R07
        end
    end

    // ==========================================================
    // Control and status
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_en && paddr == OFS_CTRL) begin
            ctrl_reg <= pwdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sts_reg <= 1'b0;
        end else if (sts_set) begin
            sts_reg <= 1'b1; // R09
        end else if (wr_en && paddr == OFS_STATUS && pwdata[STS_LOGZ]) begin
            sts_reg <= 1'b0;
        end
    end

    // ==========================================================
    // End-of-interrupt message out
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tlp_valid_reg  <= 1'b0;
            tlp_port_reg   <= '0;
            tlp_vector_reg <= 8'h00;
        end else begin
            tlp_valid_reg  <= eoi_valid && (~ctrl_reg[NPORT-1:0] != '0); // R20
            tlp_port_reg   <= eoi_valid ? ~ctrl_reg[NPORT-1:0] : '0; // R19
            tlp_vector_reg <= eoi_vector;
        end
    end

    // ==========================================================
    // APB slave: one wait-free access phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rd_set;
            pslverr <= rd_set && !(paddr == OFS_CTRL || paddr == OFS_STATUS || tbl_hit);
            if (rd_set && !pwrite) begin
                if (paddr == OFS_CTRL) begin
                    prdata <= ctrl_reg;
                end else if (paddr == OFS_STATUS) begin
                    prdata <= 32'(sts_reg) << STS_LOGZ;
                end else if (tbl_hit) begin
                    prdata <= {(tbl_idx == 5'd0) & cluster_reg, 7'h00,
                               tbl_reg[tbl_idx].physical_id_field, tbl_reg[tbl_idx].logical_id_field,
                               7'h00, tbl_reg[tbl_idx].en};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_upd_ok;
        upd_valid && upd_in.en && upd_in.logical_id_field != 8'h00 && ctrl_reg[IDCHK_BIT];
    endsequence
    sequence s_flat_req;
        msg_valid && use_flat;
    endsequence

    property p_io_dir;
        msg_valid && !msg_in.from_cpu && !hint |=> fsb_mask_reg == all_bus;
    endproperty
    a_io_dir: assert property (p_io_dir) else $error("io directed not to all"); // R01

    property p_cpu_dir;
        msg_valid && msg_in.from_cpu && !hint |=>
            !fsb_mask_reg[$past(msg_in.src_bus)] && $countones(fsb_mask_reg) == NBUS - 1;
    endproperty
    a_cpu_dir: assert property (p_cpu_dir) else $error("source bus not skipped"); // R13

    property p_redir_all;
        msg_valid && hint |=> fsb_valid_reg && fsb_mask_reg == all_bus;
    endproperty
    a_redir_all: assert property (p_redir_all) else $error("redirect not to all"); // R03

    property p_copy;
        upd_valid |=> tbl_reg[$past(upd_in.idx)].logical_id_field == $past(upd_in.logical_id_field)
                      && tbl_reg[$past(upd_in.idx)].physical_id_field == $past(upd_in.physical_id_field)
                      && tbl_reg[$past(upd_in.idx)].en == $past(upd_in.en);
    endproperty
    a_copy: assert property (p_copy) else $error("update not copied"); // R06

    property p_clu_load;
        s_upd_ok |=> cluster_reg == $past(upd_in.cluster);
    endproperty
    a_clu_load: assert property (p_clu_load) else $error("cluster bit not loaded"); // R08

    property p_clu_hold;
        upd_valid && !clu_load && !wr_en |=> $stable(cluster_reg);
    endproperty
    a_clu_hold: assert property (p_clu_hold) else $error("cluster bit moved"); // R08

    property p_sts;
        sts_set |=> sts_reg ##1 sts_reg || $past(wr_en);
    endproperty
    a_sts: assert property (p_sts) else $error("status bit 1 not set"); // R09

    property p_flat;
        s_flat_req |=> $onehot(fsb_msg_reg.addr[A_DST_LO +: 8]) && !fsb_msg_reg.addr[A_HINT];
    endproperty
    a_flat: assert property (p_flat) else $error("flat winner not one-hot"); // R15

    property p_eoi;
        eoi_valid |=> tlp_port_reg == ~$past(ctrl_reg[NPORT-1:0])
                      && tlp_vector_reg == $past(eoi_vector);
    endproperty
    a_eoi: assert property (p_eoi) else $error("eoi port mask wrong"); // R19

endmodule // imr_router

// *** dv/imr_far_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Far side: processor buses and end-of-interrupt ports
module imr_far_model #(
    parameter int NBUS  = 4,
    parameter int NPORT = 8
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 fsb_valid_reg,
    input  wire logic [NBUS-1:0]      fsb_mask_reg,
    input  wire imr_pkg::imr_msg_type fsb_msg_reg,
    input  wire logic                 tlp_valid_reg,
    input  wire logic [NPORT-1:0]     tlp_port_reg,
    input  wire logic [7:0]           tlp_vector_reg,
    output logic      [15:0]          bus_claims,
    output logic      [15:0]          eoi_taken
);
    import imr_pkg::*;
    // Every bus named in the mask of a nonzero-vector message sees one interrupt transaction
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_claims <= 16'h0000;
        end else if (fsb_valid_reg && fsb_msg_reg.vector != 8'h00) begin
            bus_claims <= bus_claims + 16'($countones(fsb_mask_reg));
        end
    end
    // Every unsuppressed port takes one end-of-interrupt message whose vector is nonzero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            eoi_taken <= 16'h0000;
        end else if (tlp_valid_reg && tlp_vector_reg != 8'h00) begin
            eoi_taken <= eoi_taken + 16'($countones(tlp_port_reg));
        end
    end
endmodule // imr_far_model

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import imr_pkg::*;
    typedef struct packed {
        logic        cpu;
        logic [1:0]  src;
        logic [19:0] addr;
        logic [3:0]  mask;
        logic [19:0] oaddr;
    } imr_row_type;
    // ==========================================
    // Ordinary routing cases, flat mode, entries 0 and 1 enabled
    localparam imr_row_type ROWS [7] = '{
        '{1'b0, 2'd0, 20'h1_0000, 4'hF, 20'h1_0000},
        '{1'b1, 2'd2, 20'h1_0000, 4'hB, 20'h1_0000},
        '{1'b1, 2'd1, 20'h1_0008, 4'hF, 20'h1_0000},
        '{1'b0, 2'd0, 20'h0_700C, 4'hF, 20'h0_1004},
        '{1'b1, 2'd0, 20'h0_7028, 4'hF, 20'h0_2020},
        '{1'b0, 2'd0, 20'h0_700C, 4'hF, 20'h0_1004},
        '{1'b0, 2'd0, 20'h0_400C, 4'hF, 20'h0_400C}};
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic msg_valid, upd_valid, eoi_valid, fsb_valid_reg, tlp_valid_reg, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  eoi_vector, tlp_port_reg, tlp_vector_reg;
    logic [3:0]  fsb_mask_reg;
    logic [15:0] bus_claims, eoi_taken;
    imr_msg_type msg_in, fsb_msg_reg;
    imr_upd_type upd_in;
    int          miscompares, compares;

    imr_router DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid), .msg_in(msg_in),
        .upd_valid(upd_valid), .upd_in(upd_in), .eoi_valid(eoi_valid),
        .eoi_vector(eoi_vector), .fsb_valid_reg(fsb_valid_reg),
        .fsb_mask_reg(fsb_mask_reg), .fsb_msg_reg(fsb_msg_reg),
        .tlp_valid_reg(tlp_valid_reg), .tlp_port_reg(tlp_port_reg),
        .tlp_vector_reg(tlp_vector_reg));
    imr_far_model far (.clk(clk), .arst_n(arst_n), .fsb_valid_reg(fsb_valid_reg),
        .fsb_mask_reg(fsb_mask_reg), .fsb_msg_reg(fsb_msg_reg),
        .tlp_valid_reg(tlp_valid_reg), .tlp_port_reg(tlp_port_reg),
        .tlp_vector_reg(tlp_vector_reg), .bus_claims(bus_claims), .eoi_taken(eoi_taken));

    always #10 clk = ~clk;

    // ==========================================
    // Shared tasks
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, starting and ending right after an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check(32'(pready), 32'h0000_0001);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic upd(input logic [4:0] i, input logic [7:0] lg, input logic [7:0] ph,
                       input logic en, input logic cl);
        upd_valid <= 1'b1;
        upd_in <= '{i, en, lg, ph, cl};
        @(posedge clk);
        upd_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic send(input logic cpu, input logic [1:0] s, input logic [19:0] a,
                        input logic [3:0] m, input logic [19:0] oa);
        msg_valid <= 1'b1;
        msg_in <= '{cpu, s, a, 8'h41};
        @(posedge clk);
        msg_valid <= 1'b0;
        #1;
        check(32'(fsb_valid_reg), 32'h0000_0001);
        check(32'(fsb_mask_reg), 32'(m));
        check(32'(fsb_msg_reg.addr), 32'(oa));
        @(posedge clk);
    endtask

    initial begin
        #300000;
        // Run needs about 110 cycles; this allows many times that
        miscompares++;
        results();
    end

    initial begin
        clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; msg_valid = 0; msg_in = '0; upd_valid = 0; upd_in = '0;
        eoi_valid = 0; eoi_vector = '0; miscompares = 0; compares = 0;
        repeat (16) @(posedge clk);
        check(32'({fsb_valid_reg, tlp_valid_reg, pready}), 32'h0000_0000);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_TABLE, 32'h0); check(q, 32'h0000_0000);
        apb(1'b0, OFS_STATUS, 32'h0); check(q, 32'h0000_0000);
        upd(5'd0, 8'h01, 8'h10, 1'b1, 1'b0);
        upd(5'd1, 8'h02, 8'h11, 1'b1, 1'b0);
        upd(5'd2, 8'h04, 8'h12, 1'b0, 1'b0);
        apb(1'b0, OFS_TABLE, 32'h0); check(q, 32'h0010_0101);
        apb(1'b0, OFS_TABLE + 12'h008, 32'h0); check(q, 32'h0012_0400);
        foreach (ROWS[i]) begin
            send(ROWS[i].cpu, ROWS[i].src, ROWS[i].addr, ROWS[i].mask,
                 ROWS[i].oaddr);
        end
        // Update then message on the very next edge
        upd_valid <= 1'b1;
        upd_in <= '{5'd2, 1'b1, 8'h04, 8'h12, 1'b0};
        @(posedge clk);
        upd_valid <= 1'b0;
        send(1'b0, 2'd0, 20'h0_400C, 4'hF, 20'h0_4004);
        upd(5'd3, 8'h21, 8'h13, 1'b1, 1'b1);
        apb(1'b0, OFS_TABLE, 32'h0); check(q, 32'h0010_0101);
        upd(5'd5, 8'h00, 8'h15, 1'b1, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0); check(q, 32'h0000_0002);
        apb(1'b1, OFS_STATUS, 32'h0000_0002);
        apb(1'b0, OFS_STATUS, 32'h0); check(q, 32'h0000_0000);
        apb(1'b1, OFS_CTRL, 32'h0000_8000);
        upd(5'd3, 8'h21, 8'h13, 1'b1, 1'b1);
        upd(5'd4, 8'h22, 8'h14, 1'b1, 1'b1);
        apb(1'b0, OFS_TABLE, 32'h0); check(q, 32'h8010_0101);
        send(1'b0, 2'd0, 20'h2_300C, 4'hF, 20'h2_1004);
        send(1'b1, 2'd1, 20'h2_3028, 4'hF, 20'h2_2020);
        send(1'b0, 2'd0, 20'h2_300C, 4'hF, 20'h2_1004);
        apb(1'b1, OFS_CTRL, 32'h0000_8005);
        eoi_valid <= 1'b1;
        eoi_vector <= 8'h33;
        @(posedge clk);
        eoi_valid <= 1'b0;
        #1;
        check(32'({tlp_valid_reg, tlp_port_reg, tlp_vector_reg}), 32'h0001_FA33);
        @(posedge clk);
        apb(1'b1, OFS_CTRL, 32'h0000_80FF);
        eoi_valid <= 1'b1;
        @(posedge clk);
        eoi_valid <= 1'b0;
        #1;
        check(32'(tlp_valid_reg), 32'h0000_0000);
        @(posedge clk);
        apb(1'b1, OFS_TEND, 32'h8033_8001);
        apb(1'b0, OFS_TEND, 32'h0); check(q, 32'h0033_8001);
        apb(1'b0, 12'h200, 32'h0); check({q[30:0], err}, 32'h0000_0001);
        check(32'({bus_claims, eoi_taken}), 32'h002B_0006);
        // Mid-run reset: cluster bit and table return to their reset state
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'({fsb_valid_reg, tlp_valid_reg, pready}), 32'h0000_0000);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_TABLE, 32'h0);
        check(q, 32'h0000_0000);
        apb(1'b0, OFS_TEND, 32'h0);
        check(q, 32'h0000_0000);
        results();
    end
endmodule // testbench
